// ===== lsb_defines.vh
// Constants for the LED sink brightness and status logic.
// Assumes inclusion by bare name from every design file of the block.
`ifndef LSB_DEFINES_VH
`define LSB_DEFINES_VH

// ************************************************
// Widths
// ************************************************
`define LSB_CHANNELS 16
`define LSB_SCALE_SR_W 8
`define LSB_SCALE_ACT_W 7
`define LSB_STATUS_W 17
`define LSB_GROUPS 4

// ************************************************
// Field positions
// ************************************************
`define LSB_REPEAT_BIT 7
`define LSB_STATUS_HEAT_BIT 16

// ************************************************
// Reset values
// ************************************************
`define LSB_SCALE_SR_RST 8'h00
`define LSB_SCALE_ACT_RST 7'h00
`define LSB_STATUS_RST 17'h00000
`define LSB_CHAN_RST 16'h0000

// ************************************************
// Timing counts in pwm_count_clock edges and i_clk cycles
// ************************************************
`define LSB_LOD_SAMPLE_CNT 16'h0020
`define LSB_PERIOD_LAST_CNT 16'hffff
`define LSB_GROUP_STEP 1

`endif

// ===== lsb_group_delay.v
// Delay line that staggers one group of sink channels.
// Assumes the input is already registered in the i_clk domain.
`include "lsb_defines.vh"

module lsb_group_delay #(
	parameter W = 4,
	parameter DEPTH = 1
) (
	// Clock, reset, enable
	input wire i_clk,
	input wire i_srst,
	input wire i_ce,
	// Channel levels
	input wire [W-1:0] i_d,
	output wire [W-1:0] o_q
);

	reg [W-1:0] stage [0:DEPTH-1];
	integer k;

	always @(posedge i_clk) begin
		if (i_srst) begin
			for (k = 0; k < DEPTH; k = k + 1) begin
				stage[k] <= {W{1'b0}};
			end
		end else if (i_ce) begin
			stage[0] <= i_d;
			for (k = 1; k < DEPTH; k = k + 1) begin
				stage[k] <= stage[k-1];
			end
		end
	end

	assign o_q = stage[DEPTH-1];

endmodule

// ===== lsb_host_model.sv
// Behavioural controller driving the serial port pins of the block.
// Assumes i_clk at 10 MHz; shift clock 800 ns a bit, standing low between frames.
module lsb_host_model (
	// Clock
	input wire i_clk,
	// Serial port pins
	output logic o_sclk,
	output logic o_sin,
	output logic o_strobe,
	output logic o_bank,
	input wire i_serial_output
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		o_sclk = 1'b0;
		o_sin = 1'b0;
		o_strobe = 1'b0;
		o_bank = 1'b0;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(posedge i_clk);
		#10;
	endtask
	// Seventeen bits MSB first; the last eight land in the scale register.
	task automatic frame(input logic bank, input logic [16:0] d, output logic [16:0] q);
		q = 17'h00000;
		o_bank = bank;
		wait_clk(4);
		for (int i = 16; i >= 0; i--) begin
			o_sin = d[i];
			wait_clk(2);
			o_sclk = 1'b1;
			wait_clk(4);
			o_sclk = 1'b0;
			wait_clk(2);
			q = {q[15:0], i_serial_output};
		end
		// A released line shows the inverse, never a stale copy of the last bit.
		o_sin = ~d[0];
	endtask
	// The tail keeps any later bank move well clear of the strobe fall.
	task automatic strobe();
		o_strobe = 1'b1;
		wait_clk(4);
		o_strobe = 1'b0;
		wait_clk(4);
	endtask
endmodule

// ===== lsb_props.sv
// Pin-level checks on the LED sink control block.
// Assumes it is bound into lsb_top and the pins move slowly against i_clk.
module lsb_props (
	// Clock and reset
	input wire i_clk,
	input wire i_srst,
	// Watched pins
	input wire i_bank_select,
	input wire i_latch_strobe,
	input wire i_blank,
	input wire i_pwm_count_clock,
	input wire i_overheat_trip,
	input wire [15:0] o_sink_channel,
	input wire o_auto_repeat,
	input wire o_fault_open_drain,
	input wire o_fault_oe_n
);
	// *****
	// Helpers
	// *****
	// Raw pin edges are counted, so the bounds leave room for the synchroniser.
	reg pwm_q;
	reg [7:0] pwm_edges;
	reg [7:0] strb_age;
	always @(posedge i_clk) begin
		pwm_q <= i_srst ? 1'b0 : i_pwm_count_clock;
		if (i_srst || i_blank) begin
			pwm_edges <= 8'h00;
		end else if (i_pwm_count_clock && !pwm_q && pwm_edges != 8'hff) begin
			pwm_edges <= pwm_edges + 8'h01;
		end
		if (i_srst || i_latch_strobe) begin
			strb_age <= 8'h00;
		end else if (strb_age != 8'hff) begin
			strb_age <= strb_age + 8'h01;
		end
	end
	// *****
	// Properties
	// *****
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_srst);
	sequence s_blank_held;
		i_blank [*8];
	endsequence
	sequence s_trip_held;
		i_overheat_trip [*6];
	endsequence
	a_od_zero: assert property (o_fault_open_drain == 1'b0)
		else $error("fault pin value not low");
	a_trip_dark: assert property ($rose(i_overheat_trip) |-> ##[1:6] o_sink_channel == 16'h0000)
		else $error("sinks stay on after trip");
	a_trip_pin_low: assert property (s_trip_held |-> !o_fault_oe_n)
		else $error("fault pin released while hot");
	a_blank_dark: assert property (i_blank [*6] |-> o_sink_channel == 16'h0000)
		else $error("sink on under blank");
	a_heat_hold: assert property (s_blank_held ##0 $rose(o_fault_oe_n) |-> strb_age < 8'h40)
		else $error("heat pin released without strobe");
	a_repeat_bank: assert property ($changed(o_auto_repeat) |-> $past(i_bank_select, 4))
		else $error("repeat bit moved with bank low");
	a_group_order: assert property ($rose(o_sink_channel[3]) |-> $past(o_sink_channel[0]))
		else $error("group four ahead of group one");
	a_open_moment: assert property ((($past(o_sink_channel) & ~o_sink_channel) != 16'h0000) &&
		!i_blank && !i_overheat_trip |-> pwm_edges == 8'h21 || pwm_edges == 8'h22)
		else $error("sink dropped away from sampling edge");
endmodule

bind lsb_top lsb_props i_props (.i_clk, .i_srst, .i_bank_select, .i_latch_strobe, .i_blank,
	.i_pwm_count_clock, .i_overheat_trip, .o_sink_channel, .o_auto_repeat,
	.o_fault_open_drain, .o_fault_oe_n);

// ===== lsb_sync.v
// Two flip-flop synchroniser for a bus of independent levels.
// Assumes each bit is a level from outside the i_clk domain.
`include "lsb_defines.vh"

module lsb_sync #(
	parameter W = 1
) (
	// Clock, reset, enable
	input wire i_clk,
	input wire i_srst,
	input wire i_ce,
	// Levels
	input wire [W-1:0] i_d,
	output reg [W-1:0] o_q
);

	reg [W-1:0] meta;

	// The first stage feeds only the second stage.
	always @(posedge i_clk) begin
		if (i_srst) begin
			meta <= {W{1'b0}};
			o_q <= {W{1'b0}};
		end else if (i_ce) begin
			meta <= i_d;
			o_q <= meta;
		end
	end

endmodule

// ===== lsb_top.v
// Brightness latches, status word readout, open-LED and thermal control
// of a 16-channel constant-current LED sink driver.
// Assumes all serial-port pins, the pwm count clock, blanking and the
// analog indications arrive asynchronously, and that i_pwm_on and
// i_level_ok come from the grayscale engine on i_clk.
//
// Functional notes
// (RULE1) Scale shift register eight bits, active seven.
// (RULE2) Seven scale bits set all channel currents.
// (RULE3) Stage-one MSB is auto-repeat, not passed on.
// (RULE4) Bank high: shift data, capture on strobe rise.
// (RULE5) Controller changes bank only while shift low.
// (RULE6) Controller loads scale before enabling outputs.
// (RULE7) Seventeen-bit status word shifts out serially.
// (RULE8) First shift after strobe falls loads status.
// (RULE9) Open flags update on 33rd count edge.
// (RULE10) Flag only channels on; one means fault.
// (RULE11) Flag reads zero below minimum pwm level.
// (RULE12) Set open flag pulls fault pin immediately.
// (RULE13) Flagged channel off until next blank fall.
// (RULE14) Blank high floats fault pin for opens.
// (RULE15) Four staggered groups, index modulo four.
// (RULE16) Overheat trips outputs off, flag, pin low.
// (RULE17) Heat flag rechecked at shift fall after strobe.
// (RULE18) Thermal error drives pin even under blank.
// (RULE19) Restart after blank fall if cooled earlier.
// (RULE20) Controller strobes and blanks once after power-up.
// (RULE21) Controller ignores open flags until sampled.
// (RULE22) Blank high forces every output off.
// (RULE23) Auto-repeat reruns period; else runs once.
// (RULE24) Stage two refreshes on 65536th count edge.
// (RULE25) Heat and low-voltage comparisons are digital inputs.
`include "lsb_defines.vh"

module lsb_top (
	// Clock, reset, enable
	input wire i_clk,
	input wire i_srst,
	input wire i_ce,
	// Serial port pins
	input wire i_serial_input,
	input wire i_shift_clock,
	input wire i_latch_strobe,
	input wire i_bank_select,
	output reg o_serial_output,
	// Display control pins
	input wire i_blank,
	input wire i_pwm_count_clock,
	// Analog indications
	input wire i_overheat_trip,
	input wire i_overheat_release,
	input wire [15:0] i_low_out,
	// Grayscale engine, same clock
	input wire [15:0] i_pwm_on,
	input wire [15:0] i_level_ok,
	input wire i_gs_chain_bit,
	// Outputs to the sinks and the fault pin
	output reg [15:0] o_sink_channel,
	output reg [6:0] o_current_scale,
	output reg o_auto_repeat,
	output reg o_period_run,
	output reg o_fault_open_drain,
	output reg o_fault_oe_n
);

	// ************************************************
	// Pin synchronisers
	// ************************************************
	wire [7:0] pin_s;
	wire [15:0] low_s;
	wire sin_s = pin_s[7];
	wire sclk_s = pin_s[6];
	wire strobe_s = pin_s[5];
	wire bank_s = pin_s[4];
	wire blank_s = pin_s[3];
	wire pclk_s = pin_s[2];
	wire trip_s = pin_s[1];
	wire release_s = pin_s[0];

	// The analog comparisons are treated as plain digital levels. [RULE25]
	lsb_sync #(
		.W(8)
	) u_sync_pins (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_ce(i_ce),
		.i_d({i_serial_input, i_shift_clock, i_latch_strobe, i_bank_select,
			i_blank, i_pwm_count_clock, i_overheat_trip, i_overheat_release}),
		.o_q(pin_s)
	);

	lsb_sync #(
		.W(16)
	) u_sync_low (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_ce(i_ce),
		.i_d(i_low_out),
		.o_q(low_s)
	);

	// ************************************************
	// Edge detection
	// ************************************************
	reg sclk_d;
	reg strobe_d;
	reg blank_d;
	reg pclk_d;
	wire sclk_rise = sclk_s & ~sclk_d;
	wire sclk_fall = ~sclk_s & sclk_d;
	wire strobe_rise = strobe_s & ~strobe_d;
	wire strobe_fall = ~strobe_s & strobe_d;
	wire blank_rise = blank_s & ~blank_d;
	wire blank_fall = ~blank_s & blank_d;
	wire pclk_rise = pclk_s & ~pclk_d;

	always @(posedge i_clk) begin
		if (i_srst) begin
			sclk_d <= 1'b0;
			strobe_d <= 1'b0;
			blank_d <= 1'b0;
			pclk_d <= 1'b0;
		end else if (i_ce) begin
			sclk_d <= sclk_s;
			strobe_d <= strobe_s;
			blank_d <= blank_s;
			pclk_d <= pclk_s;
		end
	end

	// ************************************************
	// Scale shift register and latches
	// ************************************************
	reg [7:0] scale_sr;
	reg [7:0] scale_one;
	reg [6:0] scale_act;
	wire period_end;

	// Bank select is trusted to be stable around shift edges. [RULE5]
	always @(posedge i_clk) begin
		if (i_srst) begin
			scale_sr <= `LSB_SCALE_SR_RST;
			scale_one <= `LSB_SCALE_SR_RST;
		end else if (i_ce) begin
			if (sclk_rise && bank_s) begin
				scale_sr <= {scale_sr[6:0], sin_s}; // [RULE1] [RULE4]
			end
			if (strobe_rise && bank_s) begin
				scale_one <= scale_sr; // [RULE4]
			end
		end
	end

	// Stage two takes only the low seven bits; the top bit stays behind.
	always @(posedge i_clk) begin
		if (i_srst) begin
			scale_act <= `LSB_SCALE_ACT_RST;
		end else if (i_ce) begin
			if (strobe_rise && bank_s && blank_s) begin
				scale_act <= scale_sr[6:0]; // [RULE3]
			end else if (blank_rise || period_end) begin
				scale_act <= scale_one[6:0]; // [RULE24] [RULE3]
			end
		end
	end

	// ************************************************
	// Display period sequencing
	// ************************************************
	reg running;
	reg first_period;
	reg [15:0] pwm_cnt;
	wire count_edge = pclk_rise & running & ~blank_s;
	wire lod_sample = count_edge & first_period & (pwm_cnt == `LSB_LOD_SAMPLE_CNT);

	assign period_end = count_edge & (pwm_cnt == `LSB_PERIOD_LAST_CNT);

	always @(posedge i_clk) begin
		if (i_srst) begin
			running <= 1'b0;
			first_period <= 1'b0;
			pwm_cnt <= 16'h0000;
		end else if (i_ce) begin
			if (blank_s) begin
				running <= 1'b0;
				first_period <= 1'b0;
				pwm_cnt <= 16'h0000;
			end else if (blank_fall) begin
				running <= 1'b1;
				first_period <= 1'b1;
				pwm_cnt <= 16'h0000;
			end else if (count_edge) begin
				pwm_cnt <= pwm_cnt + 16'h0001;
				if (period_end) begin
					first_period <= 1'b0;
					running <= scale_one[`LSB_REPEAT_BIT]; // [RULE23]
				end
			end
		end
	end

	// ************************************************
	// Open-LED detection and auto output off
	// ************************************************
	reg [15:0] open_led_flag;
	reg [15:0] lod_off;
	// Only channels on and above the minimum level can report a fault.
	wire [15:0] lod_hit = i_pwm_on & i_level_ok & low_s & ~lod_off; // [RULE10] [RULE11]

	always @(posedge i_clk) begin
		if (i_srst) begin
			open_led_flag <= `LSB_CHAN_RST;
			lod_off <= `LSB_CHAN_RST;
		end else if (i_ce) begin
			if (lod_sample) begin
				open_led_flag <= lod_hit; // [RULE9] [RULE10]
				lod_off <= lod_off | lod_hit; // [RULE13]
			end else if (count_edge && pwm_cnt == 16'h0000 && first_period) begin
				lod_off <= `LSB_CHAN_RST; // [RULE13]
			end
		end
	end

	// ************************************************
	// Thermal shutdown
	// ************************************************
	reg overheat_flag;
	reg overheat_shutdown;
	reg heat_check_armed;
	reg cool_at_blank;
	reg restart_armed;

	always @(posedge i_clk) begin
		if (i_srst) begin
			overheat_flag <= 1'b0;
			overheat_shutdown <= 1'b0;
			heat_check_armed <= 1'b0;
			cool_at_blank <= 1'b0;
			restart_armed <= 1'b0;
		end else if (i_ce) begin
			if (strobe_fall && !bank_s) begin
				heat_check_armed <= 1'b1;
			end else if (sclk_fall) begin
				heat_check_armed <= 1'b0;
			end
			// A trip wins over any clear in the same cycle.
			if (trip_s) begin
				overheat_flag <= 1'b1; // [RULE16]
			end else if (heat_check_armed && sclk_fall && release_s) begin
				overheat_flag <= 1'b0; // [RULE17]
			end
			if (blank_rise) begin
				cool_at_blank <= release_s & ~trip_s; // [RULE19]
			end
			if (blank_fall) begin
				restart_armed <= 1'b1;
			end else if (pclk_rise) begin
				restart_armed <= 1'b0;
			end
			if (trip_s) begin
				overheat_shutdown <= 1'b1; // [RULE16]
			end else if (restart_armed && pclk_rise && !blank_s && cool_at_blank) begin
				overheat_shutdown <= 1'b0; // [RULE19]
			end
		end
	end

	// ************************************************
	// Group stagger and sink outputs
	// ************************************************
	reg [15:0] sink_req;
	wire [15:0] sink_dly;
	wire [15:0] next_sink;
	genvar g;

	always @(posedge i_clk) begin
		if (i_srst) begin
			sink_req <= `LSB_CHAN_RST;
		end else if (i_ce) begin
			sink_req <= i_pwm_on & ~lod_off & {16{running & ~blank_s & ~overheat_shutdown}};
		end
	end

	// Group g holds channels g, g+4, g+8, g+12 and lags by g+1 steps.
	generate
		for (g = 0; g < `LSB_GROUPS; g = g + 1) begin : grp
			lsb_group_delay #(
				.W(4),
				.DEPTH((g + 1) * `LSB_GROUP_STEP)
			) u_dly (
				.i_clk(i_clk),
				.i_srst(i_srst),
				.i_ce(i_ce),
				.i_d({sink_req[g+12], sink_req[g+8], sink_req[g+4], sink_req[g]}),
				.o_q({sink_dly[g+12], sink_dly[g+8], sink_dly[g+4], sink_dly[g]}) // [RULE15]
			);
		end
	endgenerate

	// Trips, blanking and open faults bypass the stagger so shutoff is immediate.
	assign next_sink = sink_dly & ~lod_off & ~({16{lod_sample}} & lod_hit)
		& {16{~blank_s & ~trip_s & ~overheat_shutdown}}; // [RULE22] [RULE16]

	always @(posedge i_clk) begin
		if (i_srst) begin
			o_sink_channel <= `LSB_CHAN_RST;
			o_current_scale <= `LSB_SCALE_ACT_RST;
			o_auto_repeat <= 1'b0;
			o_period_run <= 1'b0;
		end else if (i_ce) begin
			o_sink_channel <= next_sink; // [RULE13] [RULE15]
			o_current_scale <= scale_act; // [RULE2]
			o_auto_repeat <= scale_one[`LSB_REPEAT_BIT]; // [RULE3]
			o_period_run <= running;
		end
	end

	// ************************************************
	// Status word and serial output
	// ************************************************
	reg [16:0] status_sr;
	reg status_load_armed;

	always @(posedge i_clk) begin
		if (i_srst) begin
			status_sr <= `LSB_STATUS_RST;
			status_load_armed <= 1'b0;
		end else if (i_ce) begin
			if (strobe_fall) begin
				status_load_armed <= 1'b1;
			end else if (sclk_rise) begin
				status_load_armed <= 1'b0;
			end
			if (sclk_rise && status_load_armed) begin
				status_sr <= {overheat_flag, open_led_flag}; // [RULE8]
			end else if (sclk_rise && !bank_s) begin
				status_sr <= {status_sr[15:0], i_gs_chain_bit}; // [RULE7]
			end
		end
	end

	always @(posedge i_clk) begin
		if (i_srst) begin
			o_serial_output <= 1'b0;
		end else if (i_ce) begin
			o_serial_output <= bank_s ? scale_sr[7] : status_sr[`LSB_STATUS_HEAT_BIT]; // [RULE7]
		end
	end

	// ************************************************
	// Fault open-drain pin
	// ************************************************
	// The pin only ever pulls low; blanking masks opens but not heat.
	wire open_now = (|open_led_flag) | (lod_sample & (|lod_hit));

	always @(posedge i_clk) begin
		if (i_srst) begin
			o_fault_open_drain <= 1'b0;
			o_fault_oe_n <= 1'b1;
		end else if (i_ce) begin
			o_fault_open_drain <= 1'b0;
			o_fault_oe_n <= ~((open_now & ~blank_s) | overheat_flag | trip_s); // [RULE12] [RULE14] [RULE18]
		end
	end

endmodule

// ===== tb.sv
// Self-checking bench for the LED sink control block.
// Assumes lsb_top, lsb_host_model and the bound checker are compiled first.
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk = 1'b0;
	logic i_srst = 1'b1;
	logic i_blank = 1'b1;
	logic i_pwm_count_clock = 1'b0;
	logic i_overheat_trip = 1'b0;
	logic i_overheat_release = 1'b1;
	logic [15:0] i_low_out = 16'h0000;
	logic [15:0] i_level_ok = 16'h0000;
	logic [15:0] pwm_on = 16'hffff;
	wire sclk, serial_input, strobe, bank, serial_output, oe_n, rep_bit, run;
	wire [15:0] sink;
	wire [6:0] scale;
	logic [16:0] q;
	logic [15:0] flags;
	logic [7:0] v;
	logic [6:0] exp_scale = 7'h00;
	logic exp_rep = 1'b0;
	integer seed = 32'h3274;
	integer fail_count = 0;
	integer comparisons = 0;
	integer cycles = 0;
	always #50 i_clk = ~i_clk;
	lsb_top i_dut (
		.i_clk(i_clk), .i_srst(i_srst), .i_ce(1'b1),
		.i_serial_input(serial_input), .i_shift_clock(sclk), .i_latch_strobe(strobe),
		.i_bank_select(bank), .o_serial_output(serial_output), .i_blank(i_blank),
		.i_pwm_count_clock(i_pwm_count_clock), .i_overheat_trip(i_overheat_trip),
		.i_overheat_release(i_overheat_release), .i_low_out(i_low_out),
		.i_pwm_on(pwm_on), .i_level_ok(i_level_ok), .i_gs_chain_bit(1'b0),
		.o_sink_channel(sink), .o_current_scale(scale), .o_auto_repeat(rep_bit),
		.o_period_run(run), .o_fault_open_drain(), .o_fault_oe_n(oe_n)
	);
	lsb_host_model i_host (.i_clk(i_clk), .o_sclk(sclk), .o_sin(serial_input), .o_strobe(strobe),
		.o_bank(bank), .i_serial_output(serial_output));
	// *****
	// Helpers
	// *****
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#10;
	endtask
	task automatic chk(input string name, input logic [16:0] exp, input logic [16:0] got);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic pulses(input int n);
		repeat (n) begin
			i_pwm_count_clock = 1'b1;
			tick(4);
			i_pwm_count_clock = 1'b0;
			tick(4);
		end
	endtask
	function automatic logic [15:0] open_flags(input logic [15:0] low, input logic [15:0] lvl,
		input logic [15:0] on);
		return low & lvl & on;
	endfunction
	task print_verdict();
		$display("Mismatches %0d comparisons %0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// The run needs about 1900 cycles; three times that means a hang.
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 6000) begin
			fail_count++;
			print_verdict();
		end
	end
	// *****
	// Sequence
	// *****
	initial begin
		tick(12);
		i_srst = 1'b0;
		tick(3);
		chk("oe_n reset", 17'h00001, {16'h0000, oe_n});
		chk("sink reset", 17'h00000, {1'b0, sink});
		// Scale writes under blank; the last has the bank low and must be ignored.
		for (int i = 0; i < 4; i++) begin
			v = (i == 0) ? 8'h80 : 8'($random(seed));
			i_host.frame(i != 3, {9'h000, v}, q);
			i_host.strobe();
			tick(8);
			if (i != 3) begin
				exp_scale = v[6:0];
				exp_rep = v[7];
			end
			chk("scale", {10'h000, exp_scale}, {10'h000, scale});
			chk("repeat", {16'h0000, exp_rep}, {16'h0000, rep_bit});
		end
		// Open channels; channels 0 and 3 are kept healthy for the order check.
		for (int k = 0; k < 2; k++) begin
			i_low_out = 16'($random(seed)) & 16'hfff6;
			i_level_ok = 16'($random(seed)) | 16'h0009;
			pwm_on = 16'($random(seed)) | 16'h0009;
			flags = open_flags(i_low_out, i_level_ok, pwm_on);
			i_blank = 1'b0;
			tick(4);
			pulses(32);
			chk("sink pre", {1'b0, pwm_on}, {1'b0, sink});
			pulses(1);
			chk("sink post", {1'b0, pwm_on & ~flags}, {1'b0, sink});
			chk("run", 17'h00001, {16'h0000, run});
			chk("oe_n open", {16'h0000, flags == 16'h0000}, {16'h0000, oe_n});
			i_blank = 1'b1;
			tick(8);
			chk("sink blank", 17'h00000, {1'b0, sink});
			chk("oe_n blank", 17'h00001, {16'h0000, oe_n});
			chk("run blank", 17'h00000, {16'h0000, run});
			i_host.strobe();
			i_host.frame(1'b0, 17'h00000, q);
			chk("status", {1'b0, flags}, q);
		end
		// Overheat with the outputs running.
		i_low_out = 16'h0000;
		pwm_on = 16'hffff;
		i_blank = 1'b0;
		tick(4);
		pulses(4);
		i_overheat_trip = 1'b1;
		i_overheat_release = 1'b0;
		tick(8);
		chk("sink trip", 17'h00000, {1'b0, sink});
		chk("oe_n trip", 17'h00000, {16'h0000, oe_n});
		i_blank = 1'b1;
		tick(8);
		chk("oe_n heat blank", 17'h00000, {16'h0000, oe_n});
		i_overheat_trip = 1'b0;
		for (int j = 0; j < 2; j++) begin
			i_host.strobe();
			i_host.frame(1'b0, 17'h00000, q);
			chk("heat bit", 17'h00001, {16'h0000, q[16]});
			chk("oe_n read", {16'h0000, j == 1}, {16'h0000, oe_n});
			i_overheat_release = 1'b1;
		end
		// The blank rise was hot, so only the second period restarts.
		for (int j = 0; j < 2; j++) begin
			i_blank = 1'b0;
			tick(4);
			pulses(4);
			chk("sink restart", {1'b0, {16{j == 1}}}, {1'b0, sink});
			i_blank = 1'b1;
			tick(8);
		end
		print_verdict();
	end
endmodule
